/* hw/slp_pkg.sv */
/*
 package for the switch and indicator port block: register offsets, reset values,
 field positions, the pattern table contents and the bus carrier structs.
 assumes a single 200 MHz clock and an AXI4-Lite master with 32-bit data.
*/
package slp_pkg;

	localparam int          SLP_PORT_W        = 8;
	localparam int          SLP_TABLE_DEPTH   = 10;
	localparam logic [15:0] SLP_TABLE_BASE    = 16'h0100;
	localparam logic [15:0] SLP_TABLE_LAST    = 16'h0109;

	// byte addresses on the register bus
	localparam logic [7:0]  SLP_OFF_P2_DIR    = 8'h00;
	localparam logic [7:0]  SLP_OFF_P2_LATCH  = 8'h04;
	localparam logic [7:0]  SLP_OFF_P2_PULL   = 8'h08;
	localparam logic [7:0]  SLP_OFF_P4_DIR    = 8'h0C;
	localparam logic [7:0]  SLP_OFF_P4_LATCH  = 8'h10;
	localparam logic [7:0]  SLP_OFF_P4_PULL   = 8'h14;
	localparam logic [7:0]  SLP_OFF_P4_VALUE  = 8'h18;
	localparam logic [7:0]  SLP_OFF_P2_VALUE  = 8'h1C;
	localparam logic [7:0]  SLP_OFF_CTRL      = 8'h20;
	localparam logic [7:0]  SLP_OFF_TBL_BASE  = 8'h40;

	localparam logic [7:0]  SLP_RST_DIR       = 8'hFF;
	localparam logic [7:0]  SLP_RST_LATCH     = 8'h00;
	localparam logic [7:0]  SLP_RST_PULL      = 8'h00;
	localparam logic [7:0]  SLP_P2_PIN_MASK   = 8'h0F;
	localparam logic [7:0]  SLP_SWITCH_MASK   = 8'h09;
	localparam int          SLP_CTRL_RUN_BIT  = 0;
	localparam logic [7:0]  SLP_RST_CTRL      = 8'h00;
	// variant reset images for port four pull-up
	localparam logic [7:0]  SLP_P4_VAR_A_SET  = 8'hC0;
	localparam logic [7:0]  SLP_P4_VAR_B_SET  = 8'hF6;

	localparam logic [7:0]  SLP_PAT_BOTH      = 8'h03;
	localparam logic [7:0]  SLP_PAT_SECOND    = 8'h05;
	localparam logic [7:0]  SLP_PAT_FIRST     = 8'h06;
	localparam logic [7:0]  SLP_PAT_NONE      = 8'h07;
	localparam logic [7:0]  SLP_PAT_DUMMY     = 8'h07;

	localparam logic [1:0]  SLP_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  SLP_RESP_SLVERR   = 2'h2;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
	} slp_wreq_t;

	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] latch;
		logic [7:0] pull;
	} slp_port_cfg_t;

endpackage

/* hw/slp_pattern_rom.sv */
/*
 pattern table: ten bytes indexed by the masked switch value.
 assumes the index comes from the same clock domain; lookup is combinational.
*/
`timescale 1ns/100ps
module slp_pattern_rom
	import slp_pkg::*;
(
	input  wire logic [3:0] index,
	output logic      [7:0] pattern
);
	logic [7:0] table_mem [SLP_TABLE_DEPTH];

	always_comb begin
		for (int i = 0; i < SLP_TABLE_DEPTH; i++) begin
			table_mem[i] = SLP_PAT_DUMMY;
		end
		table_mem[0] = SLP_PAT_BOTH;
		table_mem[1] = SLP_PAT_SECOND;
		table_mem[8] = SLP_PAT_FIRST;
		table_mem[9] = SLP_PAT_NONE;
	end

	// out-of-range indices cannot occur from a mask of bits 0 and 3
	assign pattern = (index < 4'(SLP_TABLE_DEPTH)) ? table_mem[index] : SLP_PAT_DUMMY;
endmodule // slp_pattern_rom

/* hw/slp_pin_sync.sv */
/*
 two-flop synchroniser for a bus of pin inputs.
 assumes aclk and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module slp_pin_sync #(
	parameter int W = 8
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule // slp_pin_sync

/* hw/slp_switch_led_port.sv */
/*
 switch and indicator port block: two 8-bit ports with direction, latch and
 pull-up registers behind an AXI4-Lite slave, plus a table engine that copies the
 masked port-four switch state through the pattern table into the port-two latch.
 assumes pins come from outside the clock domain and a pad ring resolves the
 pin level from output, output enable and pull-up enable.
*/
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module slp_switch_led_port
	import slp_pkg::*;
#(
	parameter int          VARIANT  = 0,   // 0 plain, 1 bits 7,6 set, 2 bits 7-4,2,1 set
	parameter int          P2_PINS  = 4
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [7:0]  port_two_in,
	output logic      [7:0]  port_two_out,
	output logic      [7:0]  port_two_oe,
	output logic      [7:0]  port_two_pull_en,
	input  wire logic [7:0]  port_four_in,
	output logic      [7:0]  port_four_out,
	output logic      [7:0]  port_four_oe,
	output logic      [7:0]  port_four_pull_en
);
	localparam logic [7:0] P4_RST_SET = (VARIANT == 1) ? SLP_P4_VAR_A_SET :
	                                    (VARIANT == 2) ? SLP_P4_VAR_B_SET : 8'h00;

	slp_port_cfg_t p2_ff;
	slp_port_cfg_t p4_ff;
	logic [7:0]    ctrl_ff;
	logic [7:0]    p2_sync;
	logic [7:0]    p4_sync;
	logic [7:0]    masked_switch_value;
	logic [7:0]    fetched_pattern;
	logic [7:0]    p2_pin_mask;

	// write and read channel state
	logic          aw_held_ff;
	logic          w_held_ff;
	logic [7:0]    awaddr_ff;
	logic [31:0]   wdata_ff;
	logic [3:0]    wstrb_ff;
	logic          bvalid_ff;
	logic [1:0]    bresp_ff;
	logic          rvalid_ff;
	logic [31:0]   rdata_ff;
	logic [1:0]    rresp_ff;
	logic          wr_fire;
	slp_wreq_t     wreq;
	logic [7:0]    wbyte;
	logic          run;

	slp_pin_sync #(
		.W(SLP_PORT_W)
	) u_sync_p2 (
		.aclk    (aclk),
		.aresetn (aresetn),
		.async_in(port_two_in),
		.sync_out(p2_sync)
	);

	slp_pin_sync #(
		.W(SLP_PORT_W)
	) u_sync_p4 (
		.aclk    (aclk),
		.aresetn (aresetn),
		.async_in(port_four_in),
		.sync_out(p4_sync)
	);

	// a pin that is an output reads back its latch, like the port read of the core
	logic [7:0] p4_value;
	logic [7:0] p2_value;
	assign p4_value = (p4_sync & p4_ff.dir) | (p4_ff.latch & ~p4_ff.dir);
	assign p2_value = (p2_sync & p2_ff.dir) | (p2_ff.latch & ~p2_ff.dir);

	assign masked_switch_value = p4_value & SLP_SWITCH_MASK;

	slp_pattern_rom u_rom (
		.index  (masked_switch_value[3:0]),
		.pattern(fetched_pattern)
	);

	assign run = ctrl_ff[SLP_CTRL_RUN_BIT];

	assign p2_pin_mask = 8'((9'h001 << P2_PINS) - 9'h001);

	// write path
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wreq    = '{addr: awaddr_ff, wdata: wdata_ff, wstrb: wstrb_ff};
	assign wbyte   = wreq.wdata[7:0];

	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready  = !w_held_ff && !bvalid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == SLP_OFF_P2_DIR)   || (a == SLP_OFF_P2_LATCH) ||
		             (a == SLP_OFF_P2_PULL)  || (a == SLP_OFF_P4_DIR)   ||
		             (a == SLP_OFF_P4_LATCH) || (a == SLP_OFF_P4_PULL)  ||
		             (a == SLP_OFF_P4_VALUE) || (a == SLP_OFF_P2_VALUE) ||
		             (a == SLP_OFF_CTRL)     ||
		             ((a >= SLP_OFF_TBL_BASE) &&
		              (a < SLP_OFF_TBL_BASE + 8'(4 * SLP_TABLE_DEPTH)) && (a[1:0] == 2'b00));
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= SLP_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= addr_known(wreq.addr) ? SLP_RESP_OKAY : SLP_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// port-two configuration and latch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p2_ff.dir   <= SLP_RST_DIR;
			p2_ff.latch <= SLP_RST_LATCH;
			p2_ff.pull  <= SLP_RST_PULL;
		end else begin
			if (wr_fire && wreq.wstrb[0] && wreq.addr == SLP_OFF_P2_DIR) begin
				p2_ff.dir <= wbyte | ~p2_pin_mask;
			end
			if (wr_fire && wreq.wstrb[0] && wreq.addr == SLP_OFF_P2_PULL) begin
				// absent pins cannot be pulled whatever software writes
				p2_ff.pull <= wbyte & p2_pin_mask;
			end
			// the table engine refreshes the latch every cycle while running
			if (run) begin
				p2_ff.latch <= fetched_pattern & p2_pin_mask;
			end else if (wr_fire && wreq.wstrb[0] && wreq.addr == SLP_OFF_P2_LATCH) begin
				p2_ff.latch <= wbyte & p2_pin_mask;
			end
		end
	end

	// port-four configuration and latch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p4_ff.dir   <= SLP_RST_DIR;
			p4_ff.latch <= SLP_RST_LATCH;
			p4_ff.pull  <= SLP_RST_PULL | P4_RST_SET;
		end else if (wr_fire && wreq.wstrb[0]) begin
			if (wreq.addr == SLP_OFF_P4_DIR) begin
				p4_ff.dir <= wbyte;
			end
			if (wreq.addr == SLP_OFF_P4_LATCH) begin
				p4_ff.latch <= wbyte;
			end
			if (wreq.addr == SLP_OFF_P4_PULL) begin
				p4_ff.pull <= wbyte;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= SLP_RST_CTRL;
		end else if (wr_fire && wreq.wstrb[0] && wreq.addr == SLP_OFF_CTRL) begin
			ctrl_ff <= {7'h00, wbyte[SLP_CTRL_RUN_BIT]};
		end
	end

	// read path
	function automatic logic [7:0] read_byte(input logic [7:0] a);
		logic [7:0] idx;
		idx = 8'h00;
		read_byte = 8'h00;
		unique case (a)
			SLP_OFF_P2_DIR:   read_byte = p2_ff.dir;
			SLP_OFF_P2_LATCH: read_byte = p2_ff.latch;
			SLP_OFF_P2_PULL:  read_byte = p2_ff.pull;
			SLP_OFF_P4_DIR:   read_byte = p4_ff.dir;
			SLP_OFF_P4_LATCH: read_byte = p4_ff.latch;
			SLP_OFF_P4_PULL:  read_byte = p4_ff.pull;
			SLP_OFF_P4_VALUE: read_byte = p4_value;
			SLP_OFF_P2_VALUE: read_byte = p2_value;
			SLP_OFF_CTRL:     read_byte = ctrl_ff;
			default: begin
				idx = 8'(a - SLP_OFF_TBL_BASE) >> 2;
				if (idx == 8'h00) read_byte = SLP_PAT_BOTH;
				else if (idx == 8'h01) read_byte = SLP_PAT_SECOND;
				else if (idx == 8'h08) read_byte = SLP_PAT_FIRST;
				else if (idx == 8'h09) read_byte = SLP_PAT_NONE;
				else if (addr_known(a)) read_byte = SLP_PAT_DUMMY;
			end
		endcase
	endfunction

	assign s_axi_arready = !rvalid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= SLP_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= {24'h000000, read_byte(s_axi_araddr)};
			rresp_ff  <= addr_known(s_axi_araddr) ? SLP_RESP_OKAY : SLP_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	// pins: a low latch lights an indicator, so no inversion here
	assign port_two_out      = p2_ff.latch;
	assign port_two_oe       = ~p2_ff.dir & p2_pin_mask;
	assign port_two_pull_en  = p2_ff.pull & p2_ff.dir;
	assign port_four_out     = p4_ff.latch;
	assign port_four_oe      = ~p4_ff.dir;
	assign port_four_pull_en = p4_ff.pull & p4_ff.dir;
endmodule // slp_switch_led_port

/* testbench/slp_switch_led_port_props.sv */
/*
 checker for the switch and indicator port block: bus handshakes, reset image,
 pin direction and the switch-to-pattern path.
 assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/100ps
module slp_switch_led_port_props (
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic		s_axi_awvalid,
	input wire logic		s_axi_awready,
	input wire logic		s_axi_wvalid,
	input wire logic		s_axi_wready,
	input wire logic		s_axi_bvalid,
	input wire logic		s_axi_bready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic		s_axi_arvalid,
	input wire logic		s_axi_arready,
	input wire logic		s_axi_rvalid,
	input wire logic		s_axi_rready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic [7:0]	port_four_in,
	input wire logic [7:0]	port_two_out,
	input wire logic [7:0]	port_two_oe,
	input wire logic [7:0]	port_two_pull_en,
	input wire logic [7:0]	port_four_out,
	input wire logic [7:0]	port_four_oe,
	input wire logic [7:0]	port_four_pull_en
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	function automatic logic [7:0] pat(input logic [7:0] v);
		case (v & 8'h09)
			8'h00: return 8'h03;
			8'h01: return 8'h05;
			8'h08: return 8'h06;
			default: return 8'h07;
		endcase
	endfunction
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_reset_image;
		$rose(aresetn) |-> port_two_oe == 8'h00 && port_four_oe == 8'h00 &&
			port_two_out == 8'h00 && port_four_out == 8'h00 && port_two_pull_en == 8'h00;
	endproperty
	a_reset_image: assert property (p_reset_image) else $error("reset image wrong");
	property p_pull_on_input;
		(port_two_pull_en & port_two_oe) == 8'h00 && (port_four_pull_en & port_four_oe) == 8'h00;
	endproperty
	a_pull_on_input: assert property (p_pull_on_input) else $error("pull-up on output");
	property p_p2_upper;
		port_two_oe[7:4] == 4'h0 && port_two_pull_en[7:4] == 4'h0;
	endproperty
	a_p2_upper: assert property (p_p2_upper) else $error("port two upper pins active");
	// software latch writes land together with the rising write response
	property p_engine;
		$changed(port_two_out) && !$rose(s_axi_bvalid) |-> port_two_out == pat($past(port_four_in, 3));
	endproperty
	a_engine: assert property (p_engine) else $error("pattern does not match switches");
	property p_wr_resp;
		s_wr_taken |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_rd_resp;
		s_rd_taken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read response wrong");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
endmodule // slp_switch_led_port_props

/* testbench/slp_sw_led_model.sv */
/*
 far side: two switches to ground on port four pins 0 and 3, indicators on
 port two pins 0 to 2. assumes switches are pressed when their input is 1.
*/
`timescale 1ns/100ps
module slp_sw_led_model (
	input wire logic		aclk,
	input wire logic		first_switch,
	input wire logic		second_switch,
	input wire logic [7:0]	port_two_out,
	input wire logic [7:0]	port_two_oe,
	input wire logic [7:0]	port_four_out,
	input wire logic [7:0]	port_four_oe,
	input wire logic [7:0]	port_four_pull_en,
	output logic [7:0]		port_two_in,
	output logic [7:0]		port_four_in,
	output logic [2:0]		lit
);
	logic flip_ff = 1'b0;
	always_ff @(posedge aclk) begin
		flip_ff <= !flip_ff;
	end
	// an undriven, unpulled pin wanders so a stale level is never trusted
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			port_two_in[i] = port_two_oe[i] ? port_two_out[i] : flip_ff;
			port_four_in[i] = port_four_oe[i] ? port_four_out[i] : port_four_pull_en[i] | flip_ff;
		end
		port_four_in[0] = port_four_in[0] & !first_switch;
		port_four_in[3] = port_four_in[3] & !second_switch;
	end
	assign lit = port_two_oe[2:0] & ~port_two_out[2:0];
endmodule // slp_sw_led_model

/* testbench/switch_led_port_control_tb.sv */
/*
 testbench for the switch and indicator port block with the switch model.
 assumes a 200 MHz clock and the register map of the block's package.
*/
`timescale 1ns/100ps
module switch_led_port_control_tb;
	import slp_pkg::*;
	typedef struct packed {logic s1; logic s2; logic [7:0] p4v; logic [7:0] pat; logic [2:0] lt;} slp_row_t;
	logic			aclk, aresetn, sw1, sw2;
	logic [7:0]		s_axi_awaddr, s_axi_araddr;
	logic [31:0]	s_axi_wdata, rd;
	logic [3:0]		s_axi_wstrb;
	logic			s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic			s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]		s_axi_bresp, s_axi_rresp, resp;
	logic [31:0]	s_axi_rdata;
	logic [7:0]		port_two_in, port_two_out, port_two_oe, port_two_pull_en;
	logic [7:0]		port_four_in, port_four_out, port_four_oe, port_four_pull_en;
	logic [2:0]		lit;
	int				fails, num_checks;
	slp_row_t		rows [4] = '{'{1, 1, 8'h00, 8'h03, 3'b100}, '{0, 1, 8'h01, 8'h05, 3'b010},
		'{1, 0, 8'h08, 8'h06, 3'b001}, '{0, 0, 8'h09, 8'h07, 3'b000}};
	logic [7:0]		tbl [10] = '{8'h03, 8'h05, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h06, 8'h07};
	slp_switch_led_port #(.VARIANT(0), .P2_PINS(4)) DUT (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_two_in, .port_two_out,
		.port_two_oe, .port_two_pull_en, .port_four_in, .port_four_out, .port_four_oe,
		.port_four_pull_en);
	slp_sw_led_model u_model (.aclk, .first_switch(sw1), .second_switch(sw2), .port_two_out,
		.port_two_oe, .port_four_out, .port_four_oe, .port_four_pull_en, .port_two_in,
		.port_four_in, .lit);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask
	// handshakes are judged at the falling edge, where every level has settled
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		logic ah, wh, dn;
		dn = 1'b0;
		// one edge apart, so a back-to-back call never reassigns a ready in the same step
		@(posedge aclk);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h0, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		for (int i = 0; i < 50 && !dn; i++) begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
			wh = s_axi_wvalid && s_axi_wready;
			dn = w ? s_axi_bvalid : s_axi_rvalid;
			resp = w ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge aclk);
			if (ah) begin
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (wh)
				s_axi_wvalid <= 1'b0;
			if (dn) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
			end
		end
		if (!dn)
			chk("bus answer", 1, 0);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#50us;
		fails++;
		wrap_up;
	end
	initial begin
		{fails, num_checks, sw1, sw2, aresetn} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("p2 oe", 8'h00, port_two_oe);
		chk("p2 out", 8'h00, port_two_out);
		chk("p4 pull", 8'h00, port_four_pull_en);
		xfer(0, SLP_OFF_P4_DIR, 0);
		chk("p4 dir", 8'hFF, rd);
		xfer(0, 8'h30, 0);
		chk("unmapped", SLP_RESP_SLVERR, resp);
		xfer(1, SLP_OFF_P2_PULL, 8'h05);
		chk("p2 pull on", 8'h05, port_two_pull_en);
		xfer(1, SLP_OFF_P2_PULL, 8'h00);
		chk("p2 pull off", 8'h00, port_two_pull_en);
		xfer(1, SLP_OFF_P2_DIR, 8'hF0);
		xfer(1, SLP_OFF_P2_LATCH, 8'h07);
		chk("p2 oe init", 8'h0F, port_two_oe);
		chk("lit init", 3'b000, lit);
		xfer(1, SLP_OFF_P4_DIR, 8'h09);
		xfer(1, SLP_OFF_P4_PULL, 8'h09);
		chk("p4 oe init", 8'hF6, port_four_oe);
		chk("p4 pull init", 8'h09, port_four_pull_en);
		$display("test reset and setup done");
		for (int i = 0; i < 10; i++) begin
			xfer(0, SLP_OFF_TBL_BASE + 8'(4 * i), 0);
			chk("table", tbl[i], rd);
		end
		$display("test table done");
		xfer(1, SLP_OFF_CTRL, 8'h01);
		foreach (rows[r]) begin
			sw1 <= rows[r].s1;
			sw2 <= rows[r].s2;
			repeat (6) @(posedge aclk);
			chk("p2 out", rows[r].pat, port_two_out);
			chk("lit", rows[r].lt, lit);
			xfer(0, SLP_OFF_P4_VALUE, 0);
			chk("p4 value", rows[r].p4v, rd);
		end
		$display("test switch rows done");
		xfer(1, SLP_OFF_P2_LATCH, 8'h00);
		repeat (3) @(posedge aclk);
		chk("refresh", 8'h07, port_two_out);
		xfer(1, SLP_OFF_CTRL, 8'h00);
		xfer(1, SLP_OFF_P2_LATCH, 8'h02);
		chk("latch stopped", 8'h02, port_two_out);
		xfer(0, SLP_OFF_P2_VALUE, 0);
		chk("p2 value", 8'h02, {4'h0, rd[3:0]});
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("p2 oe again", 8'h00, port_two_oe);
		chk("p2 out again", 8'h00, port_two_out);
		$display("test latch and second reset done");
		wrap_up;
	end
endmodule // switch_led_port_control_tb
bind slp_switch_led_port slp_switch_led_port_props u_props (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port_four_in,
	.port_two_out, .port_two_oe, .port_two_pull_en, .port_four_out, .port_four_oe,
	.port_four_pull_en);
